// file: core/scsi_port_cfg.svh
/*
 * Address map, field positions, reset values and timing counts of the
 * host command port. Assumes a 40 MHz system clock.
 */
`ifndef SCSI_PORT_CFG_SVH
`define SCSI_PORT_CFG_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define IO_BASE_ADDR 16'h3540
`define OPT_SELECT_ADDR 16'h0103
`define OFS_STAGE0 3'h0
`define OFS_STAGE1 3'h1
`define OFS_STAGE2 3'h2
`define OFS_STAGE3 3'h3
`define OFS_ATTENTION 3'h4
`define OFS_CONTROL 3'h5
`define OFS_INT_STATUS 3'h6
`define OFS_BASIC_STATUS 3'h7

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define CTRL_HW_RESET_BIT 7
`define CTRL_DMA_EN_BIT 1
`define CTRL_INT_EN_BIT 0
`define STAT_FULL_BIT 3
`define STAT_EMPTY_BIT 2
`define STAT_IRQ_BIT 1
`define STAT_BUSY_BIT 0
`define REQ_CODE_IMMEDIATE 4'h1
`define REQ_CODE_BLOCK 4'h3
`define REQ_CODE_LONG 4'h4
`define REQ_CODE_EOI 4'hE
`define REQ_CODE_LONG_ALT 4'hF
`define DEV_SUBSYSTEM 4'hF
`define DEFAULT_MAPPED_DEVS 7
`define ITYPE_SUCCESS 4'h1
`define ITYPE_RETRIED 4'h5
`define ITYPE_HW_FAIL 4'h7
`define ITYPE_IMMEDIATE 4'hA
`define ITYPE_FAILURE 4'hC
`define ITYPE_INVALID 4'hE
`define ITYPE_SEQUENCE 4'hF

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RST_BYTE 8'h00
`define RST_SCSI_ID 3'h7
`define CLK_MHZ 40
`define BUSY_NORMAL_US 50
`define RESET_SEQ_S 30
`define EOI_CLEAR_NS 250
`define BUSY_NORMAL_CYCLES (`BUSY_NORMAL_US * `CLK_MHZ)
`define RESET_SEQ_CYCLES (`RESET_SEQ_S * `CLK_MHZ * 1000000)
`define EOI_CLEAR_CYCLES (`EOI_CLEAR_NS * `CLK_MHZ / 1000)

`endif

// file: core/scsi_port_pkg.sv
/*
 * Types shared by the host command port and its device map entries.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none
package scsi_port_pkg;

    // Host I/O cycle as presented to the port.
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic setup;
        logic [7:0] wdata;
    } io_req_t;

    // Kind of work handed to the command engine.
    typedef enum logic [1:0] {
        REQ_IMMEDIATE,
        REQ_BLOCK,
        REQ_LONG_BLOCK,
        REQ_INVALID
    } req_kind_t;

    // One logical device assignment.
    typedef struct packed {
        logic assigned;
        logic reserved;
        logic [2:0] pun;
        logic [2:0] lun;
    } map_entry_t;

    // Request handed to the command engine.
    typedef struct packed {
        req_kind_t kind;
        logic [3:0] device;
        logic global_cmd;
        logic [31:0] data;
        logic [23:0] block_addr;
        map_entry_t target;
    } engine_req_t;

    // Completion posted by the command engine.
    typedef struct packed {
        logic [3:0] itype;
        logic [3:0] device;
    } post_t;

endpackage
`default_nettype wire

// file: core/device_map_entry.sv
/*
 * One logical device map entry, restored to its default on subsystem reset.
 * Assumes the engine writes assignments one entry at a time.
 */
`default_nettype none
`include "scsi_port_cfg.svh"
module device_map_entry #(
    parameter logic [3:0] INDEX = 4'h0
) (
    input wire logic clk,
    input wire logic sub_rst,
    input wire logic wr,
    input wire scsi_port_pkg::map_entry_t wdata,
    output scsi_port_pkg::map_entry_t entry
);
    import scsi_port_pkg::*;

    // Default assignment of this slot.
    wire logic is_direct = (INDEX < 4'(`DEFAULT_MAPPED_DEVS));
    wire logic is_own = (INDEX == `DEV_SUBSYSTEM);
    wire map_entry_t default_entry = '{assigned: is_direct, reserved: is_own,
                                       pun: INDEX[2:0], lun: 3'h0};

    // Entry storage; the subsystem slot cannot be reassigned.
    always_ff @(posedge clk)
    begin
        if (sub_rst)
            entry <= default_entry;
        else if (wr && !is_own)
            entry <= wdata;
    end

endmodule
`default_nettype wire

// file: core/scsi_adapter_host_command_port.sv
/*
 * Host command and status port of the bus-mastering adapter: staging bytes,
 * attention, busy handshake, basic control, interrupt status and device map.
 * Assumes synchronous host I/O strobes and a command engine that acknowledges
 * each request and posts completions on the post port.
 */
`default_nettype none
`include "scsi_port_cfg.svh"
module scsi_adapter_host_command_port #(
    parameter int unsigned BUSY_NORMAL_CYCLES = `BUSY_NORMAL_CYCLES,
    parameter int unsigned RESET_SEQ_CYCLES = `RESET_SEQ_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire scsi_port_pkg::io_req_t io,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    output logic host_interrupt_line,
    output scsi_port_pkg::engine_req_t engine_req,
    output logic engine_req_valid,
    input wire logic engine_ack,
    input wire logic engine_long_op,
    input wire logic post_valid,
    input wire scsi_port_pkg::post_t post,
    output logic post_ready,
    input wire logic map_wr,
    input wire logic [3:0] map_index,
    input wire scsi_port_pkg::map_entry_t map_wdata,
    output logic subsystem_reset,
    output logic dma_enable,
    output logic [2:0] scsi_id
);
    import scsi_port_pkg::*;

    localparam int EOI_MAX = `EOI_CLEAR_CYCLES;
    localparam int unsigned NORMAL_MAX = BUSY_NORMAL_CYCLES;

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0] stage [4];
    logic [7:0] attention;
    logic hw_reset_bit;
    logic dma_en_bit;
    logic int_en_bit;
    logic [7:0] int_status;
    logic irq_pending;
    logic busy;
    logic [31:0] busy_cnt;
    logic [3:0] stage_loaded;
    logic stage_empty;
    map_entry_t map [16];

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Eight consecutive byte registers and the option-select register.
    wire logic in_window = (io.addr[15:3] == `IO_BASE_ADDR >> 3);
    wire logic [2:0] ofs = io.addr[2:0];
    wire logic opt_hit = io.setup && (io.addr == `OPT_SELECT_ADDR);
    wire logic win_wr = io.wr && in_window;
    wire logic ro_ofs = (ofs == `OFS_INT_STATUS) || (ofs == `OFS_BASIC_STATUS);
    wire logic stage_wr = win_wr && (ofs[2] == 1'b0);
    wire logic attn_wr = win_wr && (ofs == `OFS_ATTENTION);
    wire logic ctrl_wr = win_wr && (ofs == `OFS_CONTROL) && !ro_ofs;
    wire logic opt_wr = io.wr && opt_hit;

    // Attention fields.
    wire logic [3:0] wr_code = io.wdata[7:4];
    wire logic [3:0] wr_dev = io.wdata[3:0];
    wire logic eoi_now = attn_wr && (wr_code == `REQ_CODE_EOI);
    wire logic start_now = attn_wr && !eoi_now;

    // Request classification.
    wire logic code_long = (wr_code == `REQ_CODE_LONG) || (wr_code == `REQ_CODE_LONG_ALT);
    wire req_kind_t next_kind = (wr_code == `REQ_CODE_IMMEDIATE) ? REQ_IMMEDIATE :
                                (wr_code == `REQ_CODE_BLOCK) ? REQ_BLOCK :
                                code_long ? REQ_LONG_BLOCK : REQ_INVALID;

    // Staged 32-bit value, low word from bytes 1:0.
    wire logic [31:0] staged = {stage[3], stage[2], stage[1], stage[0]};

    // Subsystem reset: channel reset or control bit 7.
    assign subsystem_reset = rst || hw_reset_bit;

    // Enables take effect only out of reset.
    assign dma_enable = dma_en_bit && !subsystem_reset;
    wire logic int_enable = int_en_bit && !subsystem_reset;

    // Completion may load status only when no interrupt is outstanding or an end-of-interrupt arrives in the same cycle.
    assign post_ready = !subsystem_reset && (!irq_pending || eoi_now);
    wire logic post_fire = post_valid && post_ready;

    // Interrupt line follows the latch gated by the enable.
    assign host_interrupt_line = irq_pending && int_enable;

    // Busy limit depends on whether a reset sequence is running.
    wire logic [31:0] busy_limit = engine_long_op ? RESET_SEQ_CYCLES : BUSY_NORMAL_CYCLES;
    wire logic busy_expired = (busy_cnt >= busy_limit - 32'd1);
    wire logic busy_clear = engine_ack || busy_expired;

    // Basic status byte.
    wire logic [7:0] basic_status = {4'h0, &stage_loaded, stage_empty, irq_pending, busy};

    // Read mux.
    wire logic [7:0] win_rdata = (ofs[2] == 1'b0) ? stage[ofs[1:0]] :
                                 (ofs == `OFS_ATTENTION) ? attention :
                                 (ofs == `OFS_CONTROL) ?
                                     {hw_reset_bit, 5'h00, dma_en_bit, int_en_bit} :
                                 (ofs == `OFS_INT_STATUS) ? int_status : basic_status;
    wire logic [7:0] next_rdata = (io.rd && in_window) ? win_rdata :
                                  (io.rd && opt_hit) ? {scsi_id, 5'h00} : 8'h00;

    // ****************************************************************
    // Option select and control
    // ****************************************************************

    // Identifier survives the control-bit reset; only channel reset restores it.
    always_ff @(posedge clk)
    begin
        if (rst)
            scsi_id <= `RST_SCSI_ID;
        else if (opt_wr)
            scsi_id <= io.wdata[7:5];
    end

    // Control register; bit 7 persists until the host clears it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hw_reset_bit <= 1'b0;
            dma_en_bit <= 1'b0;
            int_en_bit <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            hw_reset_bit <= io.wdata[`CTRL_HW_RESET_BIT];
            dma_en_bit <= io.wdata[`CTRL_DMA_EN_BIT];
            int_en_bit <= io.wdata[`CTRL_INT_EN_BIT];
        end
    end

    // ****************************************************************
    // Staging and attention
    // ****************************************************************

    // Staging bytes and the full/empty tracking.
    always_ff @(posedge clk)
    begin
        if (subsystem_reset)
        begin
            stage <= '{default: `RST_BYTE};
            attention <= `RST_BYTE;
            stage_loaded <= 4'h0;
            stage_empty <= 1'b1;
        end
        else
        begin
            if (stage_wr)
                stage[ofs[1:0]] <= io.wdata;
            if (attn_wr)
                attention <= io.wdata;
            if (start_now)
                stage_loaded <= 4'h0;
            else if (stage_wr)
                stage_loaded[ofs[1:0]] <= 1'b1;
            stage_empty <= start_now ? 1'b1 : (stage_wr ? 1'b0 : stage_empty);
        end
    end

    // Engine request, one cycle after the attention write.
    always_ff @(posedge clk)
    begin
        if (subsystem_reset)
        begin
            engine_req_valid <= 1'b0;
            engine_req <= '0;
        end
        else
        begin
            engine_req_valid <= start_now;
            if (start_now)
            begin
                engine_req.kind <= next_kind;
                engine_req.device <= wr_dev;
                engine_req.global_cmd <= (wr_dev == `DEV_SUBSYSTEM);
                engine_req.data <= staged;
                engine_req.block_addr <= staged[23:0];
                engine_req.target <= map[wr_dev];
            end
        end
    end

    // ****************************************************************
    // Busy handshake
    // ****************************************************************

    // Busy is set by an attention write or reset; the set wins over a clear.
    always_ff @(posedge clk)
    begin
        if (subsystem_reset)
        begin
            busy <= 1'b1;
            busy_cnt <= 32'd0;
        end
        else if (attn_wr)
        begin
            busy <= 1'b1;
            busy_cnt <= 32'd0;
        end
        else if (busy && busy_clear)
        begin
            busy <= 1'b0;
            busy_cnt <= 32'd0;
        end
        else if (busy)
            busy_cnt <= busy_cnt + 32'd1;
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************

    // A new completion wins over an end-of-interrupt in the same cycle.
    always_ff @(posedge clk)
    begin
        if (subsystem_reset)
        begin
            int_status <= 8'h00;
            irq_pending <= 1'b0;
        end
        else if (post_fire)
        begin
            int_status <= {post.itype, post.device};
            irq_pending <= 1'b1;
        end
        else if (eoi_now)
        begin
            int_status <= 8'h00;
            irq_pending <= 1'b0;
        end
    end

    // Read data register.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            io_rdata <= 8'h00;
            io_rvalid <= 1'b0;
        end
        else
        begin
            io_rdata <= next_rdata;
            io_rvalid <= io.rd;
        end
    end

    // ****************************************************************
    // Logical device map
    // ****************************************************************

    // Sixteen entries restored on every subsystem reset.
    for (genvar i = 0; i < 16; i++)
    begin : g_map
        device_map_entry #(
            .INDEX(4'(i))
        ) u_entry (
            .clk(clk),
            .sub_rst(subsystem_reset),
            .wr(map_wr && (map_index == 4'(i))),
            .wdata(map_wdata),
            .entry(map[i])
        );
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_attn_code(logic [3:0] c);
        attn_wr && !hw_reset_bit && (wr_code == c);
    endsequence

    sequence s_eoi_alone;
        eoi_now && !post_fire && !hw_reset_bit;
    endsequence

    AST_BUSY_ON_ATTN: assert property (attn_wr |=> busy)
        else $error("busy not set after attention write");
    AST_BUSY_BOUND: assert property (!engine_long_op && !subsystem_reset
        |-> busy_cnt < 32'(NORMAL_MAX))
        else $error("busy held past normal limit");
    AST_IMMEDIATE_REQ: assert property (s_attn_code(`REQ_CODE_IMMEDIATE)
        |=> engine_req_valid && engine_req.kind == REQ_IMMEDIATE
            && engine_req.data == $past(staged))
        else $error("immediate request not issued");
    AST_BLOCK_ADDR: assert property (s_attn_code(`REQ_CODE_BLOCK)
        |=> engine_req.kind == REQ_BLOCK && engine_req.block_addr == $past(staged[23:0]))
        else $error("block address wrong");
    AST_LONG_REQ: assert property (s_attn_code(`REQ_CODE_LONG_ALT)
        |=> engine_req.kind == REQ_LONG_BLOCK)
        else $error("long block code not classified");
    AST_EOI_CLEAR: assert property (irq_pending ##0 s_eoi_alone
        |-> ##[1:EOI_MAX] !irq_pending)
        else $error("interrupt latch not cleared after end of interrupt");
    AST_STATUS_HOLD: assert property (irq_pending && !eoi_now && !subsystem_reset
        |=> $stable(int_status) && irq_pending)
        else $error("interrupt status changed without end of interrupt");
    AST_IRQ_RAISE: assert property (post_fire && int_en_bit && !hw_reset_bit
        && !ctrl_wr |=> host_interrupt_line && int_status == $past({post.itype, post.device}))
        else $error("interrupt line not raised on status update");
    AST_HW_RESET: assert property (hw_reset_bit |-> !dma_enable && !host_interrupt_line
        ##1 busy && !engine_req_valid && !irq_pending && stage_empty)
        else $error("control reset not holding subsystem");
    AST_ID_KEEP: assert property (hw_reset_bit && !opt_wr |=> $stable(scsi_id))
        else $error("identifier disturbed by control reset");
    AST_ID_READ: assert property (io.rd && opt_hit |=> io_rdata == {scsi_id, 5'h00})
        else $error("option select read wrong");
    AST_MAP_DEFAULT: assert property ($fell(hw_reset_bit) |-> map[6].assigned
        && map[6].pun == 3'h6 && !map[7].assigned && map[15].reserved)
        else $error("default device map not restored");

endmodule
`default_nettype wire

// file: tb/host_model.sv
/*
 * Host processor model: strobed I/O writes and reads to the command port.
 * Assumes the bench pops exp_q each time the port answers a read.
 */
`default_nettype none
module host_model (
    input wire logic clk,
    output scsi_port_pkg::io_req_t io
);
    timeunit 1ns;
    timeprecision 1ns;
    import scsi_port_pkg::*;

    // Expected read answers as {mask, value}, oldest first.
    logic [15:0] exp_q[$];

    // The bus idles with no strobe from time zero.
    initial io = '0;

    // One access: the strobe holds for the edge that takes it, then data turns over.
    task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d);
        begin
            @(posedge clk);
            io <= {a, w, !w, a == 16'h0103, d};
            @(posedge clk);
            io.wr <= 1'b0;
            io.rd <= 1'b0;
            io.wdata <= ~d;
            #1;
        end
    endtask

    // Byte write.
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        access(a, 1'b1, d);
    endtask

    // Byte read whose answer is noted before the request goes out.
    task automatic rd8(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
        begin
            exp_q.push_back({m, e & m});
            access(a, 1'b0, 8'h00);
        end
    endtask
endmodule
`default_nettype wire

// file: tb/scsi_adapter_host_command_port_bench.sv
/*
 * Self-checking bench of the host command port: registers, requests, busy,
 * interrupts, control reset and device map. Assumes shortened busy limits.
 */
`default_nettype none
module scsi_adapter_host_command_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import scsi_port_pkg::*;

    logic clk, rst, io_rvalid, line, engine_req_valid, engine_ack, engine_long_op;
    logic post_valid, post_ready, map_wr, subsystem_reset, dma_enable;
    logic [7:0] io_rdata;
    logic [2:0] scsi_id, id;
    logic [3:0] map_index, dev;
    logic [15:0] note;
    logic [31:0] stage;
    io_req_t io;
    engine_req_t engine_req;
    post_t post;
    map_entry_t map_wdata;
    int bad_count, compares;
    logic [3:0] codes [5] = '{4'h1, 4'h3, 4'h4, 4'hF, 4'h2};
    logic [3:0] devs [5] = '{4'h0, 4'h6, 4'h7, 4'hE, 4'hF};
    req_kind_t kinds [5] = '{REQ_IMMEDIATE, REQ_BLOCK, REQ_LONG_BLOCK, REQ_LONG_BLOCK, REQ_INVALID};
    logic [3:0] types [7] = '{4'h1, 4'h5, 4'h7, 4'hA, 4'hC, 4'hE, 4'hF};

    host_model hm (.clk(clk), .io(io));

    scsi_adapter_host_command_port #(.BUSY_NORMAL_CYCLES(50), .RESET_SEQ_CYCLES(100)) dut (
        .clk(clk), .rst(rst), .io(io), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .host_interrupt_line(line), .engine_req(engine_req),
        .engine_req_valid(engine_req_valid), .engine_ack(engine_ack),
        .engine_long_op(engine_long_op), .post_valid(post_valid), .post(post),
        .post_ready(post_ready), .map_wr(map_wr), .map_index(map_index),
        .map_wdata(map_wdata), .subsystem_reset(subsystem_reset),
        .dma_enable(dma_enable), .scsi_id(scsi_id));

    // The 40 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare one value; a mismatch is reported and counted.
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        begin
            compares++;
            if (seen !== want)
            begin
                bad_count++;
                $display("wrong value at %0t: saw %h, wanted %h", $time, seen, want);
            end
        end
    endtask

    // Print the verdict and stop.
    task automatic conclude();
        begin
            if (bad_count == 0 && compares > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // Engine finishes the current request with a one-cycle pulse.
    task automatic ack();
        begin
            @(posedge clk);
            engine_ack <= 1'b1;
            @(posedge clk);
            engine_ack <= 1'b0;
        end
    endtask

    // Attention write; only non-end-of-interrupt codes reach the engine.
    task automatic attn(input logic [3:0] c, input logic [3:0] d);
        begin
            hm.wr8(16'h3544, {c, d});
            check(engine_req_valid, c != 4'hE);
        end
    endtask

    // Poll busy under a bound before touching staging or attention.
    task automatic wait_idle();
        int n;
        begin
            n = 0;
            do
            begin
                hm.rd8(16'h3547, 8'h00, 8'h00);
                n++;
            end
            while (io_rdata[0] !== 1'b0 && n < 200);
            check(io_rdata[0], 1'b0);
        end
    endtask

    // Load all four staging bytes, read each back, then see the full flag.
    task automatic load(input logic [31:0] v);
        begin
            for (int b = 0; b < 4; b++)
            begin
                hm.wr8(16'h3540 + 16'(b), v[8*b +: 8]);
                hm.rd8(16'h3540 + 16'(b), v[8*b +: 8], 8'hFF);
            end
            hm.rd8(16'h3547, 8'h08, 8'hFF);
        end
    endtask

    // Every read answer is matched with the oldest note.
    always @(posedge clk)
    begin
        #1;
        if (io_rvalid === 1'b1)
        begin
            note = hm.exp_q.pop_front();
            check(io_rdata & note[15:8], note[7:0]);
        end
    end

    // Cut a hang short.
    initial
    begin
        #(20000 * 25);
        bad_count++;
        conclude();
    end

    // Main sequence.
    initial
    begin
        {rst, engine_ack, engine_long_op, post_valid, map_wr} = 5'b10000;
        {post, map_index, map_wdata} = '0;
        bad_count = 0;
        compares = 0;
        void'($urandom(22));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_idle();
        check(scsi_id, 3'h7);
        hm.rd8(16'h3545, 8'h00, 8'hFF);
        id = $urandom;
        hm.wr8(16'h0103, {id, 5'h00});
        hm.rd8(16'h0103, {id, 5'h00}, 8'hFF);
        check(scsi_id, id);
        hm.wr8(16'h3546, 8'h5A);
        hm.wr8(16'h3547, 8'hA6);
        hm.rd8(16'h3546, 8'h00, 8'hFF);
        hm.rd8(16'h3548, 8'h00, 8'hFF);
        // Every request code with staged data and a spread of devices.
        foreach (codes[i])
        begin
            stage = $urandom;
            dev = devs[i];
            load(stage);
            attn(codes[i], dev);
            check(engine_req.kind, kinds[i]);
            check(engine_req.device, dev);
            check(engine_req.data, stage);
            check(engine_req.block_addr, stage[23:0]);
            check(engine_req.global_cmd, dev == 4'hF);
            check(engine_req.target[7:6], dev < 7 ? 2'b10 : {1'b0, dev == 4'hF});
            if (dev < 7)
                check(engine_req.target[5:0], {dev[2:0], 3'h0});
            hm.rd8(16'h3547, 8'h05, 8'hFF);
            ack();
            hm.rd8(16'h3547, 8'h00, 8'h01);
        end
        // Without an answer busy gives up at the normal and the long limit.
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            engine_long_op <= k[0];
            load($urandom);
            attn(4'h1, 4'hF);
            repeat (40 + 40 * k) @(posedge clk);
            hm.rd8(16'h3547, 8'h01, 8'h01);
            repeat (12 + 20 * k) @(posedge clk);
            hm.rd8(16'h3547, 8'h00, 8'h01);
        end
        @(posedge clk);
        engine_long_op <= 1'b0;
        // Each interrupt type, delivered with and without the line enabled.
        foreach (types[i])
        begin
            hm.wr8(16'h3545, {6'h00, 1'b1, i[0]});
            check(dma_enable, 1'b1);
            dev = $urandom;
            @(posedge clk);
            post <= {types[i], dev};
            post_valid <= 1'b1;
            @(posedge clk);
            post_valid <= 1'b0;
            post <= ~{types[i], dev};
            #1;
            check(line, i[0]);
            check(post_ready, 1'b0);
            hm.rd8(16'h3546, {types[i], dev}, 8'hFF);
            hm.rd8(16'h3546, {types[i], dev}, 8'hFF);
            hm.rd8(16'h3547, 8'h02, 8'h02);
            attn(4'hE, dev);
            repeat (10) @(posedge clk);
            check(line, 1'b0);
            hm.rd8(16'h3546, 8'h00, 8'hFF);
            ack();
        end
        // Reassign device 2, then a held control reset restores the map.
        @(posedge clk);
        map_wr <= 1'b1;
        map_index <= 4'h2;
        map_wdata <= 8'hA8;
        @(posedge clk);
        map_wr <= 1'b0;
        load($urandom);
        attn(4'h1, 4'h2);
        check(engine_req.target, 8'hA8);
        ack();
        hm.wr8(16'h3545, 8'h80);
        check(subsystem_reset, 1'b1);
        repeat (2000) @(posedge clk);
        hm.wr8(16'h3545, 8'h00);
        hm.rd8(16'h0103, {id, 5'h00}, 8'hFF);
        wait_idle();
        load($urandom);
        attn(4'h1, 4'h2);
        check(engine_req.target, {2'b10, 3'h2, 3'h0});
        ack();
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
